// >>> spi_port_pkg.sv
// Shared constants, register map and types for the serial port block
// Assumes one 20 MHz system clock and a 32-bit Avalon-MM register bus
// Notes on behaviour
// - Master: a data buffer write starts an exchange with self-made serial clock.
// - Master receive-only: input is sampled only during an exchange started by a buffer write, each byte loads buffer and flags.
// - Idle clock level follows clock polarity; output edge follows clock edge select.
// - Master rate: clk/4, clk/16, clk/64, timer tick/2, or clk/(4*(reload+1)).
// - With clock edge select set, output bit is valid before its first clock edge.
// - Master: sample phase picks sampling at middle or end of data output time.
// - Slave shifts on external clock pulses, flags interrupt when last bit latched.
// - Slave runs from the pin clock, also in sleep; 8 bits set flag and wake.
// - Buffer overwrite enable lets a new byte replace an unread one.
// - Mode field 0100 selects slave with slave select control.
// - Selected slave with select low enables transfer and drives its data output.
// - Select high releases the data output at once, even mid byte.
// - Select high in select mode or port disabled forces bit counter to zero.
// - Master in sleep freezes the transfer and resumes it on wake.
// - After 8 bits the byte enters the buffer, buffer full and flag set.
// - Buffer write during transfer is dropped and sets write collision.
// - Port works only while port enable is set.
package spi_port_pkg;
  localparam int unsigned CLK_HZ              = 20_000_000;
  localparam int unsigned ADDR_W              = 5;
  localparam int unsigned DATA_W              = 32;
  localparam int unsigned BYTE_BITS           = 8;
  localparam logic [4:0]  ADDR_DATA           = 5'h00;
  localparam logic [4:0]  ADDR_CTRL1          = 5'h04;
  localparam logic [4:0]  ADDR_STATUS         = 5'h08;
  localparam logic [4:0]  ADDR_CTRL3          = 5'h0c;
  localparam logic [4:0]  ADDR_RELOAD         = 5'h10;
  localparam logic [4:0]  ADDR_IRQ            = 5'h14;
  localparam logic [7:0]  RESET_BYTE          = 8'h00;
  localparam logic [7:0]  CTRL3_MASK          = 8'h10;
  localparam logic [7:0]  STATUS_WR_MASK      = 8'hc0;
  localparam logic [7:0]  IRQ_MASK            = 8'h03;
  localparam int          BIT_WRITE_COLLISION = 7;
  localparam int          BIT_RX_OVERFLOW     = 6;
  localparam int          BIT_PORT_ENABLE     = 5;
  localparam int          BIT_CLOCK_POLARITY  = 4;
  localparam int          MODE_MSB            = 3;
  localparam int          BIT_SAMPLE_PHASE    = 7;
  localparam int          BIT_CLOCK_EDGE      = 6;
  localparam int          BIT_BUFFER_FULL     = 0;
  localparam int          BIT_OVERWRITE_EN    = 4;
  localparam int          BIT_IRQ_FLAG        = 0;
  localparam int          BIT_IRQ_ENABLE      = 1;
  localparam logic [3:0]  MODE_MASTER_DIV4    = 4'h0;
  localparam logic [3:0]  MODE_MASTER_DIV16   = 4'h1;
  localparam logic [3:0]  MODE_MASTER_DIV64   = 4'h2;
  localparam logic [3:0]  MODE_MASTER_TIMER   = 4'h3;
  localparam logic [3:0]  MODE_SLAVE_SELECT   = 4'h4;
  localparam logic [3:0]  MODE_SLAVE_FREE     = 4'h5;
  localparam logic [3:0]  MODE_MASTER_RELOAD  = 4'ha;
  localparam int          DIV4                = 4;
  localparam int          DIV16               = 16;
  localparam int          DIV64               = 64;
  localparam logic [9:0]  HALF_DIV4           = 10'(DIV4 / 2);
  localparam logic [9:0]  HALF_DIV16          = 10'(DIV16 / 2);
  localparam logic [9:0]  HALF_DIV64          = 10'(DIV64 / 2);
  localparam logic [2:0]  LAST_BIT            = 3'(BYTE_BITS - 1);
  localparam logic [4:0]  STEP_ZERO           = 5'h00;
  localparam logic [4:0]  STEP_FIRST          = 5'h01;
  localparam logic [4:0]  STEP_LAST           = 5'(2 * BYTE_BITS);
  localparam int          SYN_SCLK            = 0;
  localparam int          SYN_SDI             = 1;
  localparam int          SYN_SS              = 2;
  localparam logic [2:0]  SYNC_RESET          = 3'h4;
  typedef enum logic {X_IDLE, X_SHIFT} xfer_state_t;
endpackage

// >>> spi_rate_if.sv
// Link between the transfer logic and its bit rate generator
// Assumes both ends run on the same system clock
`timescale 1ns/100ps
interface spi_rate_if;
  logic       run;
  logic       hold;
  logic [3:0] mode;
  logic [7:0] reload;
  logic       timer_tick;
  logic       half_tick;
  modport gen  (input run, hold, mode, reload, timer_tick, output half_tick);
  modport user (output run, hold, mode, reload, timer_tick, input half_tick);
endinterface

// >>> spi_rate_gen.sv
// Half bit period tick generator for master mode
// Assumes run is held for a whole transfer and hold freezes the count
`timescale 1ns/100ps
module spi_rate_gen (
  input wire logic clk,
  input wire logic reset,
  spi_rate_if.gen  rif
);
  import spi_port_pkg::*;

  logic [9:0] cnt_q;
  logic [9:0] limit;
  wire        timer_mode = rif.mode == MODE_MASTER_TIMER;
  wire        wrap       = cnt_q == limit - 10'h001;

  // Half period in system clocks for each rate
  always_comb begin
    case (rif.mode)
      MODE_MASTER_DIV16:  limit = HALF_DIV16;
      MODE_MASTER_DIV64:  limit = HALF_DIV64;
      MODE_MASTER_RELOAD: limit = {({1'b0, rif.reload} + 9'h001), 1'b0};
      default:            limit = HALF_DIV4;
    endcase
  end

  // Timer mode toggles the clock once per timer tick
  assign rif.half_tick = rif.run && !rif.hold && (timer_mode ? rif.timer_tick : wrap);

  always_ff @(posedge clk) begin
    if (reset || !rif.run) begin
      cnt_q <= 10'h000;
    end else if (rif.hold) begin
      cnt_q <= cnt_q;
    end else if (timer_mode || wrap) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
endmodule

// >>> spi_port.sv
// Serial port top: register slave, master engine, slave engine, pins
// Assumes pins are asynchronous and the bus master follows Avalon-MM
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module spi_port (
  input  wire logic                             clk,
  input  wire logic                             reset,
  input  wire logic [spi_port_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                             avs_read,
  input  wire logic                             avs_write,
  input  wire logic [spi_port_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                       avs_byteenable,
  output logic      [spi_port_pkg::DATA_W-1:0]  avs_readdata,
  output logic                                  avs_waitrequest,
  input  wire logic                             serial_clock_pin_i,
  output logic                                  serial_clock_pin_o,
  output logic                                  serial_clock_pin_oe_n,
  input  wire logic                             serial_in_pin,
  output logic                                  serial_out_pin_o,
  output logic                                  serial_out_pin_oe_n,
  input  wire logic                             slave_select_pin_n,
  input  wire logic                             second_timer_tick,
  input  wire logic                             sleep_mode,
  output logic                                  wake_req
);
  import spi_port_pkg::*;

  // Register file
  logic [7:0]  buf_q;
  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl1_d;
  logic [7:0]  stat_q;
  logic [7:0]  stat_d;
  logic [7:0]  ctrl3_q;
  logic [7:0]  reload_q;
  logic [7:0]  irq_q;
  logic [7:0]  irq_d;
  logic        ack_q;
  logic [DATA_W-1:0] readdata_q;
  logic        wake_q;

  // Transfer state
  xfer_state_t xfer_q;
  logic [4:0]  step_q;
  logic        sclk_q;
  logic [2:0]  bit_q;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;

  // Pin synchronisers
  logic [2:0]  s1_q;
  logic [2:0]  s2_q;
  logic [2:0]  s3_q;
  logic [2:0]  filt_q;
  logic [2:0]  filt_d;

  spi_rate_if rif ();

  spi_rate_gen u_rate (
    .clk   (clk),
    .reset (reset),
    .rif   (rif)
  );

  // Returns {shift, sample} for one clock edge
  function automatic logic [1:0] edge_act(input logic lead, input logic first,
                                          input logic cke, input logic sample_phase,
                                          input logic last);
    logic sh;
    logic sa;
    sh = cke ? !lead : (lead && !first);
    sa = cke ? lead : !lead;
    if (sample_phase) begin
      sa = sh || (!cke && last);
    end
    edge_act = {sh, sa};
  endfunction

  // Control decode
  wire [7:0] wbyte     = avs_writedata[7:0];
  wire [3:0] mode      = ctrl1_q[MODE_MSB:0];
  wire       en        = ctrl1_q[BIT_PORT_ENABLE];
  wire       cpol      = ctrl1_q[BIT_CLOCK_POLARITY];
  wire       cke       = stat_q[BIT_CLOCK_EDGE];
  wire       sample_phase       = stat_q[BIT_SAMPLE_PHASE];
  wire       buffer_overwrite_enable      = ctrl3_q[BIT_OVERWRITE_EN];
  wire       bf        = stat_q[BIT_BUFFER_FULL];
  wire       slave_md  = mode == MODE_SLAVE_SELECT || mode == MODE_SLAVE_FREE;
  wire       is_slave  = en && slave_md;
  wire       is_master = en && !slave_md;
  wire       ss_mode   = is_slave && mode == MODE_SLAVE_SELECT;
  wire       deselect  = ss_mode && filt_q[SYN_SS];
  wire       slave_live = is_slave && !deselect;

  // Bus decode
  wire       req       = avs_read || avs_write;
  wire       fin       = req && ack_q;
  wire       wr        = avs_write && fin && avs_byteenable[0];
  wire       wr_buf    = wr && avs_address == ADDR_DATA;
  wire       wr_ctrl1  = wr && avs_address == ADDR_CTRL1;
  wire       wr_stat   = wr && avs_address == ADDR_STATUS;
  wire       wr_ctrl3  = wr && avs_address == ADDR_CTRL3;
  wire       wr_reload = wr && avs_address == ADDR_RELOAD;
  wire       wr_irq    = wr && avs_address == ADDR_IRQ;
  wire       rd_buf    = avs_read && fin && avs_address == ADDR_DATA;
  wire [7:0] rd_byte   = (avs_address == ADDR_DATA)   ? buf_q    :
                         (avs_address == ADDR_CTRL1)  ? ctrl1_q  :
                         (avs_address == ADDR_STATUS) ? stat_q   :
                         (avs_address == ADDR_CTRL3)  ? ctrl3_q  :
                         (avs_address == ADDR_RELOAD) ? reload_q :
                         (avs_address == ADDR_IRQ)    ? irq_q    : RESET_BYTE;

  // Edge decode
  wire [4:0] k         = step_q + STEP_FIRST;
  wire       sclk_edge = filt_d[SYN_SCLK] != filt_q[SYN_SCLK];
  wire       s_lead    = filt_d[SYN_SCLK] != cpol;
  wire [1:0] act_m     = edge_act(k[0], k == STEP_FIRST, cke, sample_phase, k == STEP_LAST);
  wire [1:0] act_s     = edge_act(s_lead, bit_q == 3'h0, cke, 1'b0, 1'b0);
  wire       m_go      = xfer_q == X_SHIFT && rif.half_tick;
  wire       s_go      = slave_live && sclk_edge;
  wire       do_shift  = (m_go && act_m[1]) || (s_go && act_s[1]);
  wire       do_samp   = (m_go && act_m[0]) || (s_go && act_s[0]);
  wire       m_done    = m_go && k == STEP_LAST;
  wire       s_done    = s_go && act_s[0] && bit_q == LAST_BIT;
  wire       byte_done = m_done || s_done;
  wire [7:0] rx_next   = {rx_q[BYTE_BITS-2:0], filt_d[SYN_SDI]};
  // Byte end on a non-sampling edge keeps the byte already shifted in
  wire [7:0] rx_byte   = do_samp ? rx_next : rx_q;
  wire       load_ok   = !bf || buffer_overwrite_enable;
  wire       busy      = xfer_q == X_SHIFT || (is_slave && bit_q != 3'h0);
  wire       buf_ok    = wr_buf && !busy;
  wire       coll_set  = wr_buf && busy;
  wire       start     = buf_ok && is_master;
  wire       drive     = is_master || (is_slave && !(ss_mode && slave_select_pin_n));

  assign rif.run        = xfer_q == X_SHIFT;
  assign rif.hold       = sleep_mode;
  assign rif.mode       = mode;
  assign rif.reload     = reload_q;
  assign rif.timer_tick = second_timer_tick;

  // Outputs
  assign avs_waitrequest       = req && !ack_q;
  assign avs_readdata          = readdata_q;
  assign serial_clock_pin_o    = sclk_q;
  assign serial_clock_pin_oe_n = !is_master;
  assign serial_out_pin_o      = tx_q[BYTE_BITS-1];
  assign serial_out_pin_oe_n   = !drive;
  assign wake_req              = wake_q;
  assign filt_d                = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));

  // Pin sampling
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q   <= SYNC_RESET;
      s2_q   <= SYNC_RESET;
      s3_q   <= SYNC_RESET;
      filt_q <= SYNC_RESET;
    end else begin
      s1_q   <= {slave_select_pin_n, serial_in_pin, serial_clock_pin_i};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Bus slave: one wait cycle per access
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q      <= 1'b0;
      readdata_q <= '0;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        readdata_q <= {{(DATA_W-BYTE_BITS){1'b0}}, rd_byte};
      end
    end
  end

  // Register next values; hardware sets win over software clears
  always_comb begin
    ctrl1_d = wr_ctrl1 ? wbyte : ctrl1_q;
    if (coll_set) begin
      ctrl1_d[BIT_WRITE_COLLISION] = 1'b1;
    end
    if (byte_done && !load_ok) begin
      ctrl1_d[BIT_RX_OVERFLOW] = 1'b1;
    end
  end

  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = (wbyte & STATUS_WR_MASK) | (stat_q & ~STATUS_WR_MASK);
    end
    if (rd_buf) begin
      stat_d[BIT_BUFFER_FULL] = 1'b0;
    end
    if (byte_done && load_ok) begin
      stat_d[BIT_BUFFER_FULL] = 1'b1;
    end
  end

  always_comb begin
    irq_d = irq_q;
    if (wr_irq) begin
      irq_d[BIT_IRQ_ENABLE] = wbyte[BIT_IRQ_ENABLE];
      if (wbyte[BIT_IRQ_FLAG]) begin
        irq_d[BIT_IRQ_FLAG] = 1'b0;
      end
    end
    if (byte_done) begin
      irq_d[BIT_IRQ_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl1_q  <= RESET_BYTE;
      stat_q   <= RESET_BYTE;
      ctrl3_q  <= RESET_BYTE;
      reload_q <= RESET_BYTE;
      irq_q    <= RESET_BYTE;
      wake_q   <= 1'b0;
    end else begin
      ctrl1_q  <= ctrl1_d;
      stat_q   <= stat_d;
      irq_q    <= irq_d & IRQ_MASK;
      wake_q   <= irq_q[BIT_IRQ_FLAG] && irq_q[BIT_IRQ_ENABLE];
      if (wr_ctrl3) begin
        ctrl3_q <= wbyte & CTRL3_MASK;
      end
      if (wr_reload) begin
        reload_q <= wbyte;
      end
    end
  end

  // Receive buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_q <= RESET_BYTE;
    end else if (buf_ok) begin
      buf_q <= wbyte;
    end else if (byte_done && load_ok) begin
      buf_q <= rx_byte;
    end
  end

  // Shift registers
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_q <= RESET_BYTE;
      rx_q <= RESET_BYTE;
    end else begin
      if (buf_ok) begin
        tx_q <= wbyte;
      end else if (do_shift) begin
        tx_q <= tx_q << 1;
      end
      if (do_samp) begin
        rx_q <= rx_next;
      end
    end
  end

  // Master engine and serial clock
  always_ff @(posedge clk) begin
    if (reset) begin
      xfer_q <= X_IDLE;
      step_q <= STEP_ZERO;
      sclk_q <= 1'b0;
    end else if (!is_master) begin
      xfer_q <= X_IDLE;
      step_q <= STEP_ZERO;
      sclk_q <= cpol;
    end else if (start) begin
      xfer_q <= X_SHIFT;
      step_q <= STEP_ZERO;
    end else if (m_go) begin
      step_q <= k;
      sclk_q <= !sclk_q;
      if (k == STEP_LAST) begin
        xfer_q <= X_IDLE;
      end
    end else if (xfer_q == X_IDLE) begin
      sclk_q <= cpol;
    end
  end

  // Slave bit counter
  always_ff @(posedge clk) begin
    if (reset || !en || deselect) begin
      bit_q <= 3'h0;
    end else if (s_go && act_s[0]) begin
      bit_q <= bit_q + 3'h1;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start_cke;
    start && cke;
  endsequence

  sequence s_slave_last;
    s_done;
  endsequence

  AST_START_SHIFT: assert property (start |=> xfer_q == X_SHIFT)
    else $error("Master did not start on buffer write");

  AST_RX_ONLY: assert property (m_done && load_ok |=> buf_q == $past(rx_byte))
    else $error("Received byte not loaded");

  AST_IDLE_LEVEL: assert property (is_master && xfer_q == X_IDLE && !start
                                   |=> serial_clock_pin_o == $past(cpol))
    else $error("Idle clock level wrong");

  AST_DIV4_RATE: assert property (m_go && mode == MODE_MASTER_DIV4 && k != STEP_LAST
                                  |-> ##1 !rif.half_tick
                                  ##1 (rif.half_tick || sleep_mode || $past(sleep_mode)))
    else $error("Divide by four rate wrong");

  AST_CKE_FIRST: assert property (s_start_cke |=> serial_out_pin_o == $past(wbyte[BYTE_BITS-1])
                                  && step_q == STEP_ZERO)
    else $error("First bit not ready before first edge");

  AST_SLAVE_FLAG: assert property (s_slave_last |=> irq_q[BIT_IRQ_FLAG] && bit_q == 3'h0)
    else $error("Slave byte end did not flag");

  AST_WAKE: assert property (s_slave_last ##1 irq_q[BIT_IRQ_ENABLE] |=> wake_req)
    else $error("Wake not raised");

  AST_OVERWRITE: assert property (byte_done && bf && !buffer_overwrite_enable
                                  |=> $stable(buf_q) && ctrl1_q[BIT_RX_OVERFLOW])
    else $error("Unread byte overwritten");

  AST_SS_RELEASE: assert property (ss_mode && slave_select_pin_n |-> serial_out_pin_oe_n)
    else $error("Data output driven while deselected");

  AST_BIT_RESET: assert property (deselect || (!en && $past(en)) |=> bit_q == 3'h0)
    else $error("Bit counter not cleared");

  AST_SLEEP_HOLD: assert property (sleep_mode && xfer_q == X_SHIFT && !start
                                   |=> $stable(step_q) && $stable(sclk_q))
    else $error("Transfer moved in sleep");

  AST_LOAD_FLAGS: assert property (byte_done && load_ok && !rd_buf
                                   |=> bf && irq_q[BIT_IRQ_FLAG])
    else $error("Buffer full or flag missing");

  AST_COLLISION: assert property (coll_set && !byte_done |=> ctrl1_q[BIT_WRITE_COLLISION]
                                  && $stable(xfer_q))
    else $error("Collision not flagged");

  AST_DISABLED: assert property (!en |=> xfer_q == X_IDLE && bit_q == 3'h0)
    else $error("Port active while disabled");
endmodule

// >>> spi_far_end.sv
// Far side of the serial link: reactive slave, or timed master with select
// Assumes the bench resolves shared pin levels and hands them in
`timescale 1ns/100ps
module spi_far_end (
  input  wire logic dut_master,
  input  wire logic sclk_line,
  input  wire logic sdo_line,
  output logic      sclk_m,
  output logic      ss_n,
  output logic      sdi
);
  logic [7:0] rxs;
  logic [7:0] txs;
  logic       msdo;
  initial begin
    sclk_m = 1'b0;
    ss_n   = 1'b1;
    msdo   = 1'b0;
    txs    = 8'h00;
    rxs    = 8'h00;
  end
  assign sdi = dut_master ? txs[7] : msdo;
  // Slave role: sample on rise, next bit on fall
  always @(posedge sclk_line) if (dut_master) rxs <= {rxs[6:0], sdo_line};
  always @(negedge sclk_line) if (dut_master) txs <= {txs[6:0], ~txs[0]};
  task automatic load(input logic [7:0] b);
    txs = b;
  endtask
  // Master role: 400 ns clock, data sampled at end of high phase
  task automatic frame(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    #13;
    ss_n = 1'b0;
    msdo = tx[7];
    #400;
    for (int i = 0; i < nbits; i++) begin
      sclk_m = 1'b1;
      #190;
      rx = {rx[6:0], sdo_line};
      #10;
      sclk_m = 1'b0;
      tx = {tx[6:0], 1'b0};
      msdo = tx[7];
      #200;
    end
    ss_n = 1'b1;
    msdo = ~msdo;
  endtask
endmodule

// >>> spi_port_tb.sv
// Self-checking bench for the serial port top
// Assumes spi_far_end stands on the serial pins as the other party
`timescale 1ns/100ps
module spi_port_tb;
  import spi_port_pkg::*;
  localparam int RELOAD_V = 2;
  localparam int TICK_GAP = 5;
  logic        clk, reset, avs_read, avs_write, sleep_mode, second_timer_tick;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rs;
  logic        avs_waitrequest, sclk_o, sclk_oe_n, sdo_o, sdo_oe_n, wake_req;
  logic        sclk_m, ss_n, sdi, flt, s;
  logic [2:0]  tcnt;
  logic [7:0]  b0, b1, rx;
  logic [15:0] expq[$];
  int          errors, compares;
  wire sclk_line = sclk_oe_n ? sclk_m : sclk_o;
  wire sdo_line  = sdo_oe_n ? flt : sdo_o;
  spi_port i_spi_port (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clock_pin_i(sclk_line), .serial_clock_pin_o(sclk_o),
    .serial_clock_pin_oe_n(sclk_oe_n), .serial_in_pin(sdi), .serial_out_pin_o(sdo_o),
    .serial_out_pin_oe_n(sdo_oe_n), .slave_select_pin_n(ss_n),
    .second_timer_tick(second_timer_tick), .sleep_mode(sleep_mode), .wake_req(wake_req));
  spi_far_end i_spi_far_end (.dut_master(~sclk_oe_n), .sclk_line(sclk_line),
    .sdo_line(sdo_line), .sclk_m(sclk_m), .ss_n(ss_n), .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    flt <= ~flt;
    tcnt <= (tcnt == 3'(TICK_GAP - 1)) ? 3'h0 : tcnt + 3'h1;
    second_timer_tick <= (tcnt == 3'(TICK_GAP - 1));
  end
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timeout();
    errors++;
    $display("ERROR %0t wait ran out", $time);
    summarize();
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    compares++;
    if ((got & msk) !== (exp & msk)) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read results checked as they appear, oldest note first
  always @(posedge clk) if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
    check(avs_readdata[7:0], expq[0][7:0], expq[0][15:8]);
    check({7'h0, |avs_readdata[31:8]}, 8'h00, 8'hff);
    void'(expq.pop_front());
  end
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) timeout();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake_req !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) timeout();
    bus(1'b1, ADDR_IRQ, 8'h03);
  endtask
  task automatic half_period(input int exp);
    int n;
    n = 0;
    while (sclk_o !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) timeout();
    n = 0;
    while (sclk_o === 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) timeout();
    check(8'(n), 8'(exp), 8'hff);
  endtask
  task automatic slave_byte(input logic [7:0] b);
    i_spi_far_end.frame(b, 8, rx);
    repeat (8) @(posedge clk);
  endtask
  logic [3:0] modes[5] = '{MODE_MASTER_DIV4, MODE_MASTER_DIV16, MODE_MASTER_DIV64,
                           MODE_MASTER_TIMER, MODE_MASTER_RELOAD};
  int halves[5] = '{DIV4 / 2, DIV16 / 2, DIV64 / 2, TICK_GAP, 2 * (RELOAD_V + 1)};
  initial begin
    {reset, avs_read, avs_write, sleep_mode, second_timer_tick, flt} = 6'b100000;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    tcnt = 3'h0;
    rs = 32'hcfcd8fa9;
    errors = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    foreach (modes[i]) rd(5'(4 * i), 8'h00, 8'hff);
    rd(5'h1c, 8'h00, 8'hff);
    bus(1'b1, ADDR_IRQ, 8'h02);
    bus(1'b1, ADDR_STATUS, 8'h40);
    bus(1'b1, ADDR_RELOAD, 8'(RELOAD_V));
    bus(1'b1, ADDR_CTRL1, 8'h30);
    repeat (2) @(posedge clk);
    check({7'h0, sclk_o}, 8'h01, 8'h01);
    foreach (modes[i]) begin
      bus(1'b1, ADDR_CTRL1, {4'h2, modes[i]});
      bus(1'b1, ADDR_DATA, rnd());
      half_period(halves[i]);
      wait_wake();
      rd(ADDR_STATUS, 8'h01, 8'h01);
      rd(ADDR_DATA, 8'h00, 8'h00);
    end
    b0 = rnd();
    b1 = rnd();
    bus(1'b1, ADDR_CTRL1, {4'h2, MODE_MASTER_DIV16});
    i_spi_far_end.load(b1);
    bus(1'b1, ADDR_DATA, b0);
    bus(1'b1, ADDR_DATA, ~b0);
    repeat (20) @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    s = sclk_o;
    repeat (40) begin
      @(posedge clk);
      check({7'h0, sclk_o}, {7'h0, s}, 8'h01);
    end
    sleep_mode <= 1'b0;
    wait_wake();
    check(i_spi_far_end.rxs, b0, 8'hff);
    rd(ADDR_STATUS, 8'h01, 8'h01);
    rd(ADDR_DATA, b1, 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'h01);
    rd(ADDR_CTRL1, 8'h80, 8'h80);
    bus(1'b1, ADDR_CTRL1, {4'h2, MODE_SLAVE_SELECT});
    repeat (4) @(posedge clk);
    check({7'h0, sclk_oe_n}, 8'h01, 8'h01);
    bus(1'b1, ADDR_DATA, b0);
    b1 = rnd();
    i_spi_far_end.frame(b1, 8, rx);
    check(rx, b0, 8'hff);
    wait_wake();
    rd(ADDR_DATA, b1, 8'hff);
    i_spi_far_end.frame(rnd(), 3, rx);
    #1;
    check({7'h0, sdo_oe_n}, 8'h01, 8'h01);
    repeat (8) @(posedge clk);
    b0 = rnd();
    slave_byte(b0);
    slave_byte(rnd());
    rd(ADDR_CTRL1, 8'h40, 8'h40);
    rd(ADDR_DATA, b0, 8'hff);
    bus(1'b1, ADDR_CTRL3, 8'h10);
    slave_byte(rnd());
    b1 = rnd();
    slave_byte(b1);
    rd(ADDR_DATA, b1, 8'hff);
    summarize();
  end
endmodule
